//--- pm_cfg_map.svh
/*
  register offsets, field positions, reset values and timing counts for the
  bios timer decode and stop-clock control block.
  assumes: included by the package and the port checker, bare name.
*/
`ifndef PM_CFG_MAP_SVH
`define PM_CFG_MAP_SVH

// register offsets (byte addresses on the plain register port)
`define OFF_BIOS_TIMER_IO_BASE     8'h80
`define OFF_POWER_MGMT_CONTROL     8'ha0
`define OFF_IDLE_TIMER_RELOAD      8'ha8
`define OFF_SCALE_HIGH_TIME        8'hb0
`define OFF_SCALE_LOW_TIME         8'hb4
`define OFF_IRQ_STATUS             8'hc0
`define OFF_IRQ_MASK               8'hc4

// reset values
`define RST_BIOS_TIMER_IO_BASE     16'h0078
`define RST_POWER_MGMT_CONTROL     8'h08
`define RST_IDLE_TIMER_RELOAD      8'h0f
`define RST_SCALE_TIME             16'h0010

// writable bit masks, reserved bits read zero
`define MASK_BIOS_TIMER_IO_BASE    16'hfffd
`define MASK_POWER_MGMT_CONTROL    8'h4f

// power_mgmt_control fields, and the access enable bit 0 of bios_timer_io_base
`define BIT_MGMT_INTERRUPT_GATE    0
`define BIT_STOP_CLOCK_OUT_EN      1
`define BIT_STOP_CLOCK_SCALE_EN    2
`define BIT_IDLE_TIMER_FREEZE      3
`define BIT_STOP_GRANT_WAIT_DIS    6
`define BIT_ACCESS_ENABLE          0

// irq status bits
`define IRQ_IDLE_EXPIRE            0
`define IRQ_STOP_CLOCK_ASSERT      1
`define IRQ_STOP_CLOCK_RELEASE     2
`define IRQ_WIDTH                  3

// one minute and the 250 MHz clock period, in ns
`define MINUTE_NS                  64'd60000000000
`define CLK_PERIOD_NS              64'd4

`endif

//--- pm_cfg_pkg.sv
/*
  types for the bios timer decode and stop-clock control block.
  assumes: pm_cfg_map.svh is available on the include path.
*/
package pm_cfg_pkg;
  `include "pm_cfg_map.svh"

  // one register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

  // one host io cycle seen by the decoder
  typedef struct packed {
    logic [15:0] addr;
    logic        io_cycle;
  } io_probe_type;

  // stop-clock output sequencer states
  typedef enum logic [3:0] {
    clk_run   = 4'b0001,
    clk_stop  = 4'b0010,
    clk_grant = 4'b0100,
    clk_high  = 4'b1000
  } stop_state_type;
endpackage : pm_cfg_pkg

//--- phase_timer.sv
/*
  reloadable down counter with a terminal pulse.
  assumes: single clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module phase_timer
  import pm_cfg_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk,    // block clock
  input  wire logic         rst_b,  // sync reset, low active
  input  wire logic         load,   // load start value
  input  wire logic [W-1:0] start,  // start value
  input  wire logic         run,    // count enable
  output logic              done    // pulse on reaching zero
);
  logic [W-1:0] count;

  // count down while run, report the step into zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count <= '0;
      done  <= 1'b0;
    end else if (load) begin
      count <= start;
      done  <= 1'b0;
    end else if (run && count != '0) begin
      count <= count - W'(1);
      done  <= (count == W'(1));
    end else begin
      done  <= 1'b0;
    end
  end
endmodule : phase_timer

//--- pm_cfg.sv
/*
  bios timer i/o decode and cpu stop-clock power management control.
  assumes: plain register port from host logic on clk; io probe, command port
  strobes and stop-grant arrive from pins and are synchronised here.
*/
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
//
// Operation
// - bios timer decoded where base bits 15:2 equal io address 15:2.
// - bios timer decode only while access enable bit 0 is set; resets clear.
// - bit 6 clear waits for stop grant before releasing stop clock.
// - freeze bit 3 halts the idle timer, no time-out.
// - scaling and enable both set time high/low phases from scaling timers.
// - scaling bit clear means no scaling control of stop clock.
// - enable set plus command port read asserts stop clock low.
// - enable clear holds stop clock high, except while waiting for stop grant with bit 6 clear.
// - enable cleared by writing zero or any command port write.
// - gate bit 0 clear masks management interrupt; set lets pending assert.
// - idle timer counts minutes; at zero raises interrupt and reloads.
module pm_cfg
  import pm_cfg_pkg::*;
#(
  parameter longint MINUTE_CYCLES = `MINUTE_NS / `CLK_PERIOD_NS
) (
  input  wire logic        clk,               // 250 MHz block clock
  input  wire logic        rst_b,             // sync reset, low active
  input  wire logic [7:0]  reg_addr,          // register byte address
  input  wire logic [15:0] reg_wdata,         // register write data
  input  wire logic        reg_wr,            // write strobe
  input  wire logic        reg_rd,            // read strobe
  output logic      [15:0] reg_rdata,         // read data, cycle after strobe
  input  wire logic [15:0] io_addr,           // host io address pins
  input  wire logic        io_cycle,          // host io cycle valid pin
  output logic             bios_timer_hit,    // decode hit for bios timer
  input  wire logic        cmd_port_rd,       // command port read pin
  input  wire logic        cmd_port_wr,       // command port write pin
  input  wire logic        stop_grant,        // stop grant cycle seen pin
  input  wire logic        wake_event,        // break event pin
  output logic             cpu_stop_clock_n,  // stop clock to cpu, low active
  output logic             mgmt_interrupt_n,  // management interrupt, low active
  output logic             irq                // level interrupt to software
);
  localparam longint MIN_CNT = (MINUTE_CYCLES < 1) ? 1 : MINUTE_CYCLES;

  reg_req_type     req;
  io_probe_type    probe;
  stop_state_type  state;
  stop_state_type  next_state;

  logic [15:0] bios_timer_io_base;
  logic [7:0]  power_mgmt_control;
  logic [7:0]  idle_timer_reload;
  logic [15:0] scale_high_time;
  logic [15:0] scale_low_time;
  logic [`IRQ_WIDTH-1:0] irq_status;
  logic [`IRQ_WIDTH-1:0] irq_mask;
  logic [`IRQ_WIDTH-1:0] irq_event;
  logic [7:0]  idle_count;
  logic [35:0] minute_count;
  logic        mgmt_pending;
  logic        idle_expire;

  // synchroniser stages for pin inputs
  logic [16:0] io_s1, io_s2;
  logic [3:0]  pin_s1, pin_s2, pin_s3;
  logic        cmd_rd_pulse, cmd_wr_pulse, grant_pulse, wake_pulse;

  // register port bundling
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // two flops on every pin input, third stage for edge detection
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      io_s1  <= 17'h00000;
      io_s2  <= 17'h00000;
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
    end else begin
      io_s1  <= {io_cycle, io_addr};
      io_s2  <= io_s1;
      pin_s1 <= {wake_event, stop_grant, cmd_port_wr, cmd_port_rd};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // rising edges of synchronised strobes
  assign cmd_rd_pulse = pin_s2[0] & ~pin_s3[0];
  assign cmd_wr_pulse = pin_s2[1] & ~pin_s3[1];
  assign grant_pulse  = pin_s2[2] & ~pin_s3[2];
  assign wake_pulse   = pin_s2[3] & ~pin_s3[3];
  assign probe        = '{addr: io_s2[15:0], io_cycle: io_s2[16]};

  // bios timer base register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bios_timer_io_base <= `RST_BIOS_TIMER_IO_BASE;
    end else if (req.wr && req.addr == `OFF_BIOS_TIMER_IO_BASE) begin
      bios_timer_io_base <= req.wdata & `MASK_BIOS_TIMER_IO_BASE;
    end
  end

  // bios timer decode, registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bios_timer_hit <= 1'b0;
    end else begin
      bios_timer_hit <= probe.io_cycle
                        && bios_timer_io_base[`BIT_ACCESS_ENABLE]
                        && (probe.addr[15:2] == bios_timer_io_base[15:2]);
    end
  end

  // power management control register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      power_mgmt_control <= `RST_POWER_MGMT_CONTROL;
    end else begin
      if (req.wr && req.addr == `OFF_POWER_MGMT_CONTROL) begin
        power_mgmt_control <= req.wdata[7:0] & `MASK_POWER_MGMT_CONTROL;
      end
      if (cmd_wr_pulse) begin
        power_mgmt_control[`BIT_STOP_CLOCK_OUT_EN] <= 1'b0;
      end
    end
  end

  // idle reload and scaling timer registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      idle_timer_reload <= `RST_IDLE_TIMER_RELOAD;
      scale_high_time   <= `RST_SCALE_TIME;
      scale_low_time    <= `RST_SCALE_TIME;
    end else if (req.wr) begin
      if (req.addr == `OFF_IDLE_TIMER_RELOAD) begin
        idle_timer_reload <= req.wdata[7:0];
      end
      if (req.addr == `OFF_SCALE_HIGH_TIME) begin
        scale_high_time <= req.wdata;
      end
      if (req.addr == `OFF_SCALE_LOW_TIME) begin
        scale_low_time <= req.wdata;
      end
    end
  end

  // minute prescaler, halted while frozen
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      minute_count <= 36'h000000000;
    end else if (power_mgmt_control[`BIT_IDLE_TIMER_FREEZE]) begin
      minute_count <= minute_count;
    end else if (minute_count >= 36'(MIN_CNT - 1)) begin
      minute_count <= 36'h000000000;
    end else begin
      minute_count <= minute_count + 36'h000000001;
    end
  end

  // idle timer: one step per minute, reload and flag at zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      idle_count  <= `RST_IDLE_TIMER_RELOAD;
      idle_expire <= 1'b0;
    end else begin
      idle_expire <= 1'b0;
      if (!power_mgmt_control[`BIT_IDLE_TIMER_FREEZE]
          && minute_count == 36'(MIN_CNT - 1)) begin
        if (idle_count <= 8'h01) begin
          idle_count  <= idle_timer_reload;
          idle_expire <= 1'b1;
        end else begin
          idle_count <= idle_count - 8'h01;
        end
      end
    end
  end

  // management interrupt pending latch, cleared by command port write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mgmt_pending <= 1'b0;
    end else if (idle_expire) begin
      mgmt_pending <= 1'b1;
    end else if (cmd_wr_pulse) begin
      mgmt_pending <= 1'b0;
    end
  end

  // management interrupt pin, gated
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mgmt_interrupt_n <= 1'b1;
    end else begin
      mgmt_interrupt_n <= ~(mgmt_pending
                            & power_mgmt_control[`BIT_MGMT_INTERRUPT_GATE]);
    end
  end

  // scaling phase timers
  logic high_done, low_done, high_load, low_load;
  logic scaling;
  assign scaling = power_mgmt_control[`BIT_STOP_CLOCK_SCALE_EN]
                   & power_mgmt_control[`BIT_STOP_CLOCK_OUT_EN];

  phase_timer #(.W(16)) low_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .load  (low_load),
    .start (scale_low_time),
    .run   (state == clk_stop && scaling),
    .done  (low_done)
  );

  phase_timer #(.W(16)) high_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .load  (high_load),
    .start (scale_high_time),
    .run   (state == clk_high),
    .done  (high_done)
  );

  // stop clock sequencer next state
  always_comb begin
    next_state = state;
    low_load   = 1'b0;
    high_load  = 1'b0;
    case (state)
      clk_run: begin
        if (power_mgmt_control[`BIT_STOP_CLOCK_OUT_EN] && cmd_rd_pulse) begin
          next_state = clk_stop;
          low_load   = 1'b1;
        end
      end
      clk_stop: begin
        if (!power_mgmt_control[`BIT_STOP_CLOCK_OUT_EN] || wake_pulse
            || (scaling && low_done)) begin
          next_state = power_mgmt_control[`BIT_STOP_GRANT_WAIT_DIS]
                       ? clk_high : clk_grant;
          high_load  = 1'b1;
        end
      end
      clk_grant: begin
        if (grant_pulse) begin
          next_state = clk_high;
          high_load  = 1'b1;
        end
      end
      clk_high: begin
        if (!scaling) begin
          next_state = clk_run;
        end else if (high_done) begin
          next_state = clk_stop;
          low_load   = 1'b1;
        end
      end
      default: next_state = clk_run;
    endcase
  end

  // sequencer state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= clk_run;
    end else begin
      state <= next_state;
    end
  end

  // stop clock pin, low in stop and grant-wait phases
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cpu_stop_clock_n <= 1'b1;
    end else if (!power_mgmt_control[`BIT_STOP_CLOCK_OUT_EN]
                 && next_state != clk_grant && next_state != clk_stop) begin
      cpu_stop_clock_n <= 1'b1;
    end else begin
      cpu_stop_clock_n <= ~(next_state == clk_stop || next_state == clk_grant);
    end
  end

  // interrupt events
  assign irq_event[`IRQ_IDLE_EXPIRE]        = idle_expire;
  assign irq_event[`IRQ_STOP_CLOCK_ASSERT]  = (state != clk_stop) && (next_state == clk_stop);
  assign irq_event[`IRQ_STOP_CLOCK_RELEASE] = (state == clk_grant) && (next_state == clk_high)
                                              || (state == clk_stop && next_state == clk_high);

  // sticky status, write one to clear, set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_status <= '0;
    end else if (req.wr && req.addr == `OFF_IRQ_STATUS) begin
      irq_status <= (irq_status & ~req.wdata[`IRQ_WIDTH-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  // interrupt mask
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_mask <= '0;
    end else if (req.wr && req.addr == `OFF_IRQ_MASK) begin
      irq_mask <= req.wdata[`IRQ_WIDTH-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (req.rd) begin
      case (req.addr)
        `OFF_BIOS_TIMER_IO_BASE: reg_rdata <= bios_timer_io_base;
        `OFF_POWER_MGMT_CONTROL: reg_rdata <= {8'h00, power_mgmt_control};
        `OFF_IDLE_TIMER_RELOAD:  reg_rdata <= {8'h00, idle_timer_reload};
        `OFF_SCALE_HIGH_TIME:    reg_rdata <= scale_high_time;
        `OFF_SCALE_LOW_TIME:     reg_rdata <= scale_low_time;
        `OFF_IRQ_STATUS:         reg_rdata <= {13'h0000, irq_status};
        `OFF_IRQ_MASK:           reg_rdata <= {13'h0000, irq_mask};
        default:                 reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : pm_cfg

//--- pm_cfg_chk.sv
/* port checker for pm_cfg: read data, decode and pin release timing.
   assumes: bound to pm_cfg below; one clock, sync active-low reset. */
`timescale 1ns/1ps
`include "pm_cfg_map.svh"
module pm_cfg_chk (
  input wire logic        clk,              // clock
  input wire logic        rst_b,            // reset
  input wire logic [7:0]  reg_addr,         // address
  input wire logic [15:0] reg_wdata,        // wdata
  input wire logic        reg_wr,           // write
  input wire logic        reg_rd,           // read
  input wire logic [15:0] reg_rdata,        // rdata
  input wire logic [15:0] io_addr,          // io address
  input wire logic        io_cycle,         // io valid
  input wire logic        bios_timer_hit,   // hit
  input wire logic        cmd_port_rd,      // cmd read
  input wire logic        cmd_port_wr,      // cmd write
  input wire logic        stop_grant,       // grant
  input wire logic        wake_event,       // wake
  input wire logic        cpu_stop_clock_n, // stop clock
  input wire logic        mgmt_interrupt_n  // mgmt irq
);
  logic [15:0] base;
  logic [3:0]  age_rd;
  logic [3:0]  age_rel;
  logic        scl;     // shadow of the scaling enable bit
  wire         ctl_wr = reg_wr && reg_addr == 8'ha0;
  // shadow of the decode base, ages of the last trigger pins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      base    <= `RST_BIOS_TIMER_IO_BASE;
      age_rd  <= 4'hf;
      age_rel <= 4'hf;
      scl     <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h80)
        base <= reg_wdata & `MASK_BIOS_TIMER_IO_BASE;
      age_rd  <= cmd_port_rd ? 4'h0 : age_rd + 4'(age_rd != 4'hf);
      age_rel <= (cmd_port_wr || wake_event || stop_grant || ctl_wr) ? 4'h0
               : age_rel + 4'(age_rel != 4'hf);
      // scaling restarts the phases on its own timers, no pin involved
      if (ctl_wr)
        scl <= reg_wdata[2];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence rd_of(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_base_resv: assert property (rd_of(8'h80) |=> !reg_rdata[1])
    else $error("base reserved bit reads one");
  a_ctl_resv: assert property (rd_of(8'ha0) |=> (reg_rdata & 16'hffb0) == 16'h0000)
    else $error("control reserved bits read one");
  a_unmapped_zero: assert property (reg_rd && !(reg_addr inside
    {8'h80, 8'ha0, 8'ha8, 8'hb0, 8'hb4, 8'hc0, 8'hc4}) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_hit_match: assert property (bios_timer_hit |-> $past(io_cycle, 3) && $past(base[0])
    && $past(io_addr[15:2], 3) == $past(base[15:2]))
    else $error("decode hit without matching enabled cycle");
  a_stop_cause: assert property ($fell(cpu_stop_clock_n) && !scl && !$past(scl)
    |-> age_rd <= 4'h5)
    else $error("stop clock asserted without command read");
  a_stop_release: assert property ($rose(cpu_stop_clock_n) && !scl && !$past(scl)
    |-> age_rel <= 4'h6)
    else $error("stop clock released without cause");
  a_mgmt_release: assert property ($rose(mgmt_interrupt_n) |-> age_rel <= 4'h6)
    else $error("mgmt interrupt released without cause");
endmodule : pm_cfg_chk
bind pm_cfg pm_cfg_chk chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .io_addr(io_addr), .io_cycle(io_cycle), .bios_timer_hit(bios_timer_hit),
  .cmd_port_rd(cmd_port_rd), .cmd_port_wr(cmd_port_wr), .stop_grant(stop_grant),
  .wake_event(wake_event), .cpu_stop_clock_n(cpu_stop_clock_n),
  .mgmt_interrupt_n(mgmt_interrupt_n));

//--- cpu_model.sv
/* host cpu model: answers an asserted stop clock with one stop grant.
   assumes: shares clk with pm_cfg; the testbench gates the reply. */
`timescale 1ns/1ps
module cpu_model #(
  parameter int DELAY = 6
) (
  input  wire logic clk,              // clock
  input  wire logic rst_b,            // reset
  input  wire logic cpu_stop_clock_n, // stop request
  input  wire logic grant_en,         // reply allowed
  output logic      stop_grant        // grant pin
);
  logic [7:0] wait_cnt;
  logic       granted;
  // two-cycle grant a while after stop, once per stop phase
  always_ff @(posedge clk) begin
    if (!rst_b || cpu_stop_clock_n) begin
      wait_cnt   <= 8'h00;
      granted    <= 1'b0;
      stop_grant <= 1'b0;
    end else if (grant_en && !granted) begin
      wait_cnt   <= wait_cnt + 8'h01;
      stop_grant <= wait_cnt >= 8'(DELAY);
      granted    <= wait_cnt == 8'(DELAY + 1);
    end else
      stop_grant <= 1'b0;
  end
endmodule : cpu_model

//--- tb_bios_timer_decode_and_stop_clock_ctl.sv
/* testbench for pm_cfg: registers, decode, stop clock, idle timer, irq.
   assumes: pm_cfg_chk bound in its file; cpu_model plays the cpu. */
`timescale 1ns/1ps
module tb_bios_timer_decode_and_stop_clock_ctl;
  logic        clk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] io_addr;
  logic        io_cycle;
  logic [2:0]  pins;  // cmd read, cmd write, wake
  logic        grant_en;
  logic        stop_grant;
  logic        hit;
  logic        stop_n;
  logic        mgmt_n;
  logic        irq;
  int          num_errors;
  int          checks;
  int          n;
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  pm_cfg #(.MINUTE_CYCLES(10)) DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .io_addr(io_addr), .io_cycle(io_cycle), .bios_timer_hit(hit),
    .cmd_port_rd(pins[0]), .cmd_port_wr(pins[1]), .stop_grant(stop_grant),
    .wake_event(pins[2]), .cpu_stop_clock_n(stop_n), .mgmt_interrupt_n(mgmt_n),
    .irq(irq));
  cpu_model CPU (.clk(clk), .rst_b(rst_b), .cpu_stop_clock_n(stop_n),
    .grant_en(grant_en), .stop_grant(stop_grant));
  // compare one value, pins zero-extended
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, e);
  endtask : rd
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : idle
  // two-cycle pulse on one pin, then settle
  task automatic pulse(input int k);
    @(posedge clk);
    pins[k] <= 1'b1;
    repeat (2) @(posedge clk);
    pins[k] <= 1'b0;
    idle(6);
  endtask : pulse
  task automatic results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  // main sequence
  initial begin
    rst_b     = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    io_addr   = 16'h0078;
    io_cycle  = 1'b1;
    pins      = 3'h0;
    grant_en  = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h80, 16'h0078);
    rd(8'ha0, 16'h0008);
    rd(8'h90, 16'h0000);
    cmp(hit, 1'b0);
    wr(8'h80, 16'h007b);
    rd(8'h80, 16'h0079);
    idle(6);
    cmp(hit, 1'b1);
    @(posedge clk) io_addr <= 16'h007b;
    idle(6);
    cmp(hit, 1'b1);
    @(posedge clk) io_addr <= 16'h007c;
    idle(6);
    cmp(hit, 1'b0);
    @(posedge clk) io_addr <= 16'h4078;
    idle(6);
    cmp(hit, 1'b0);
    @(posedge clk) io_cycle <= 1'b0;
    wr(8'ha0, 16'h0038);
    rd(8'ha0, 16'h0008);
    pulse(0);
    cmp(stop_n, 1'b1);
    wr(8'ha0, 16'h004a);
    pulse(0);
    cmp(stop_n, 1'b0);
    idle(40);
    cmp(stop_n, 1'b0);
    pulse(2);
    cmp(stop_n, 1'b1);
    wr(8'ha0, 16'h004a);
    pulse(0);
    cmp(stop_n, 1'b0);
    wr(8'ha0, 16'h0048);
    idle(2);
    cmp(stop_n, 1'b1);
    // scaling: high and low phases of eight timer counts each, no grant wait
    wr(8'hb0, 16'h0008);
    wr(8'hb4, 16'h0008);
    wr(8'ha0, 16'h004e);
    pulse(0);
    cmp(stop_n, 1'b0);
    n = 0;
    while (stop_n !== 1'b1 && n < 40) begin
      idle(1);
      n++;
    end
    n = 0;
    while (stop_n === 1'b1 && n < 40) begin
      idle(1);
      n++;
    end
    cmp(n >= 8 && n <= 10, 1'b1);
    n = 0;
    while (stop_n === 1'b0 && n < 40) begin
      idle(1);
      n++;
    end
    cmp(n >= 8 && n <= 10, 1'b1);
    wr(8'ha0, 16'h0048);
    idle(2);
    cmp(stop_n, 1'b1);
    wr(8'ha0, 16'h000a);
    pulse(0);
    cmp(stop_n, 1'b0);
    pulse(1);
    rd(8'ha0, 16'h0008);
    cmp(stop_n, 1'b0);
    @(posedge clk) grant_en <= 1'b1;
    idle(20);
    cmp(stop_n, 1'b1);
    wr(8'hc4, 16'h0001);
    wr(8'ha8, 16'h0002);
    wr(8'ha0, 16'h0009);
    idle(200);
    cmp(mgmt_n, 1'b1);
    cmp(irq, 1'b0);
    wr(8'ha0, 16'h0001);
    n = 0;
    while (mgmt_n !== 1'b0 && n < 400) begin
      idle(1);
      n++;
    end
    cmp(mgmt_n, 1'b0);
    wr(8'hc0, 16'h0001);
    cmp(irq, 1'b0);
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      idle(1);
      n++;
    end
    cmp(n >= 6 && n <= 22, 1'b1);
    wr(8'hc4, 16'h0000);
    cmp(irq, 1'b0);
    wr(8'hc4, 16'h0001);
    cmp(irq, 1'b1);
    wr(8'ha0, 16'h0008);
    idle(3);
    cmp(mgmt_n, 1'b1);
    rd(8'hc0, 16'h0007);
    results();
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule : tb_bios_timer_decode_and_stop_clock_ctl
